// ===== hdl/freq_limit_dc_brake_stop.sv
// frequency command conditioning and stop sequencing with dc braking, classic wishbone slave
// Functional notes
// - top frequency 40.00..400.00 Hz, default 60.00; other frequencies never exceed it
// - start frequency 0.10..10.00 Hz, default 0.50; commands below it become zero
// - with limit enable the running frequency stays between lower and upper limits
// - lower limit from start to upper, default 0.50; upper to top, default 60.00
// - the commanded setting is clamped to the limits while limit enable is set
// - with jump enable the command never settles inside any of three bands
// - bands default 10-15, 20-25, 30-35 Hz; low bound never above high bound
// - band bounds accepted only between start and top frequency
// - rising setting inside a band holds output at the band low bound
// - falling setting inside a band holds output at the band high bound
// - ramping across a band skips it; output never runs inside a band
// - stop mode 1 decelerates, then injects dc at the brake start frequency
// - output blocked for pre-brake time 0.00..60.00 s before injection
// - dc is applied for the braking duration 0.0..60.0 s, default 1.0 s
// - brake amount 0..200 percent of rated current scales injected current
// - brake start frequency from start frequency to 60.00 Hz, default 5.00
// - zero brake amount or zero duration skips dc braking entirely
// - controller gain follows the inertia rate setting 0, 1 or 2
// - stop mode 0 ramps down to 0 Hz with no dc injection
// - stop mode 2 switches output off at once and lets the motor coast
`timescale 1ns/100ps
`default_nettype none
module freq_limit_dc_brake_stop
   import freq_brake_pkg::*;
#(
   parameter int          TICK_CYCLES = TICK_CYCLES_DOC,
   parameter logic [15:0] RAMP_STEP   = 16'h0064
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   output logic      [15:0] freq_out_o,
   output logic             output_on_o,
   output logic             dc_inject_o,
   output logic      [15:0] dc_current_o,
   output logic      [1:0]  brake_gain_o,
   output logic             stop_done_o
);
   localparam int TW = $clog2(TICK_CYCLES);
   localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

   // ***********************************************************
   // settings
   // ***********************************************************
   logic        run_reg;
   logic [1:0]  mode_reg;
   logic        limit_en_reg;
   logic        jump_en_reg;
   logic [1:0]  inertia_reg;
   logic [15:0] top_reg;
   logic [15:0] start_reg;
   logic [15:0] lower_reg;
   logic [15:0] upper_reg;
   logic [15:0] jlo_reg [3];
   logic [15:0] jhi_reg [3];
   logic [15:0] pre_block_reg;
   logic [15:0] dc_dur_reg;
   logic [15:0] dc_amt_reg;
   logic [15:0] brake_freq_reg;
   logic [15:0] cmd_reg;
   logic [15:0] rated_reg;
   logic        ack_reg;
   logic [31:0] rdata_reg;

   // ***********************************************************
   // bus decode
   // ***********************************************************
   wire         req      = cyc_i & stb_i & ~ack_reg;
   wire         wr       = req & we_i & sel_i[0] & sel_i[1];
   wire  [15:0] wd       = dat_i[15:0];
   wire  [1:0]  wd_mode  = dat_i[CTRL_MODE_LSB+1:CTRL_MODE_LSB];
   wire  [1:0]  wd_inert = dat_i[CTRL_INERTIA_LSB+1:CTRL_INERTIA_LSB];
   wire         wr_ctrl  = wr & (adr_i == OFS_CTRL) & (wd_mode <= MODE_MAX) & (wd_inert <= INERTIA_MAX);
   wire         wr_start = wr & (adr_i == OFS_START_FREQ) & (wd >= START_MIN) & (wd <= START_MAX)
                           & (wd <= lower_reg) & (wd <= brake_freq_reg);
   wire         wr_lower = wr & (adr_i == OFS_LOWER_LIM) & (wd >= start_reg) & (wd <= upper_reg);
   wire         wr_upper = wr & (adr_i == OFS_UPPER_LIM) & (wd >= lower_reg) & (wd <= top_reg);
   wire         wr_pre   = wr & (adr_i == OFS_PRE_BLOCK) & (wd <= PRE_BLOCK_MAX);
   wire         wr_dur   = wr & (adr_i == OFS_DC_DUR) & (wd <= DC_DUR_MAX);
   wire         wr_amt   = wr & (adr_i == OFS_DC_AMT) & (wd <= DC_AMT_MAX);
   wire         wr_brake = wr & (adr_i == OFS_BRAKE_FREQ) & (wd >= start_reg) & (wd <= BRAKE_FREQ_MAX)
                           & (wd <= top_reg);
   wire         wr_cmd   = wr & (adr_i == OFS_CMD_FREQ);
   wire         wr_rated = wr & (adr_i == OFS_RATED_CUR);
   logic [2:0]  top_ok_band;
   wire         wr_top   = wr & (adr_i == OFS_TOP_FREQ) & (wd >= TOP_MIN) & (wd <= TOP_MAX)
                           & (wd >= upper_reg) & (wd >= brake_freq_reg) & (&top_ok_band);

   // ***********************************************************
   // conditioning chain
   // ***********************************************************
   logic [15:0] out_reg;
   wire  [15:0] f_clamp = (cmd_reg < start_reg) ? 16'h0000 :
                          (cmd_reg > top_reg) ? top_reg : cmd_reg;
   wire  [15:0] f_limit = !limit_en_reg ? f_clamp :
                          (f_clamp > upper_reg) ? upper_reg :
                          (f_clamp < lower_reg) ? lower_reg : f_clamp;
   wire         rising  = f_limit > out_reg;
   logic [2:0]  set_in;
   logic [2:0]  wr_jlo;
   logic [2:0]  wr_jhi;
   logic [2:0]  step_in;
   logic [15:0] step_val;

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_band
         localparam logic [7:0] OFS_LO = OFS_JUMP_BASE + 8'(8 * g);
         localparam logic [7:0] OFS_HI = OFS_JUMP_BASE + 8'(8 * g + 4);
         assign wr_jlo[g]      = wr & (adr_i == OFS_LO) & (wd >= start_reg) & (wd <= jhi_reg[g]);
         assign wr_jhi[g]      = wr & (adr_i == OFS_HI) & (wd >= jlo_reg[g]) & (wd <= top_reg);
         assign top_ok_band[g] = wd >= jhi_reg[g];
         assign set_in[g]      = jump_en_reg & (f_limit > jlo_reg[g]) & (f_limit < jhi_reg[g]);
         assign step_in[g]     = jump_en_reg & (step_val > jlo_reg[g]) & (step_val < jhi_reg[g]);
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               jlo_reg[g] <= JLO_RST[g];
               jhi_reg[g] <= JHI_RST[g];
            end else begin
               if (wr_jlo[g]) jlo_reg[g] <= wd;
               if (wr_jhi[g]) jhi_reg[g] <= wd;
            end
         end
      end
   endgenerate

   // first band that holds the setting decides the held edge
   wire  [1:0]  hit_idx  = set_in[0] ? 2'd0 : set_in[1] ? 2'd1 : 2'd2;
   wire  [1:0]  step_idx = step_in[0] ? 2'd0 : step_in[1] ? 2'd1 : 2'd2;
   wire  [15:0] f_target = !(|set_in) ? f_limit :
                           rising ? jlo_reg[hit_idx] : jhi_reg[hit_idx];

   // ***********************************************************
   // stop sequencer
   // ***********************************************************
   stop_state_e state_reg;
   stop_state_e state_next;
   logic [TW-1:0] tick_cnt_reg;
   logic [16:0] timer_reg;
   logic        done_reg;
   wire         tick       = tick_cnt_reg == TICK_LAST;
   wire  [15:0] goal       = (state_reg == ST_DECEL) ? 16'h0000 : f_target;
   wire  [16:0] up_sum     = {1'b0, out_reg} + {1'b0, RAMP_STEP};
   wire  [15:0] up_val     = (up_sum[15:0] > goal || up_sum[16]) ? goal : up_sum[15:0];
   wire  [15:0] dn_val     = (out_reg < goal + RAMP_STEP) ? goal : out_reg - RAMP_STEP;
   wire         ramp_up    = goal > out_reg;
   assign step_val         = ramp_up ? up_val : dn_val;
   // a ramp step that lands inside a band is moved to the far edge
   wire  [15:0] ramp_val   = !(|step_in) ? step_val :
                             ramp_up ? jhi_reg[step_idx] : jlo_reg[step_idx];
   wire         skip_dc    = (dc_amt_reg == 16'h0000) || (dc_dur_reg == 16'h0000);
   wire  [16:0] dur_ticks  = 17'(dc_dur_reg * DUR_TICKS_UNIT);
   wire         block_over = timer_reg >= {1'b0, pre_block_reg};
   wire         brake_over = timer_reg >= dur_ticks;
   wire         at_brake   = out_reg <= brake_freq_reg;
   wire  [31:0] cur_prod   = dc_amt_reg * rated_reg;
   wire  [15:0] cur_val    = 16'(cur_prod / PERCENT_FULL);

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (run_reg) state_next = ST_RUN;
         end
         ST_RUN: begin
            if (!run_reg) begin
               if (mode_reg == STOP_COAST) state_next = ST_DONE;
               else state_next = ST_DECEL;
            end
         end
         ST_DECEL: begin
            if (run_reg) state_next = ST_RUN;
            else if (mode_reg == STOP_DC && at_brake) begin
               if (skip_dc) state_next = ST_DONE;
               else state_next = ST_BLOCK;
            end else if (out_reg == 16'h0000) state_next = ST_DONE;
         end
         ST_BLOCK: begin
            if (block_over) state_next = ST_INJECT;
         end
         ST_INJECT: begin
            if (brake_over) state_next = ST_DONE;
         end
         ST_DONE: state_next = ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg    <= ST_IDLE;
         tick_cnt_reg <= '0;
         timer_reg    <= '0;
         out_reg      <= 16'h0000;
         done_reg     <= 1'b0;
      end else begin
         state_reg    <= state_next;
         tick_cnt_reg <= (tick || state_next != state_reg) ? '0 : tick_cnt_reg + 1'b1;
         if (state_next != state_reg) timer_reg <= '0;
         else if (tick) timer_reg <= timer_reg + 17'h0_0001;
         if (state_next != ST_RUN && state_next != ST_DECEL) out_reg <= 16'h0000;
         else if (tick) out_reg <= ramp_val;
         if (state_reg == ST_DONE) done_reg <= 1'b1;
         else if (state_next == ST_RUN) done_reg <= 1'b0;
      end
   end

   // ***********************************************************
   // register writes
   // ***********************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_reg        <= 1'b0;
         mode_reg       <= STOP_DECEL;
         limit_en_reg   <= 1'b0;
         jump_en_reg    <= 1'b0;
         inertia_reg    <= 2'h0;
         top_reg        <= TOP_RST;
         start_reg      <= START_RST;
         lower_reg      <= LOWER_RST;
         upper_reg      <= UPPER_RST;
         pre_block_reg  <= PRE_BLOCK_RST;
         dc_dur_reg     <= DC_DUR_RST;
         dc_amt_reg     <= DC_AMT_RST;
         brake_freq_reg <= BRAKE_FREQ_RST;
         cmd_reg        <= 16'h0000;
         rated_reg      <= RATED_CUR_RST;
      end else begin
         if (wr_ctrl) begin
            run_reg      <= dat_i[CTRL_RUN_BIT];
            mode_reg     <= wd_mode;
            limit_en_reg <= dat_i[CTRL_LIMIT_BIT];
            jump_en_reg  <= dat_i[CTRL_JUMP_BIT];
            inertia_reg  <= wd_inert;
         end
         if (wr_top) top_reg <= wd;
         if (wr_start) start_reg <= wd;
         if (wr_lower) lower_reg <= wd;
         if (wr_upper) upper_reg <= wd;
         if (wr_pre) pre_block_reg <= wd;
         if (wr_dur) dc_dur_reg <= wd;
         if (wr_amt) dc_amt_reg <= wd;
         if (wr_brake) brake_freq_reg <= wd;
         if (wr_cmd) cmd_reg <= wd;
         if (wr_rated) rated_reg <= wd;
      end
   end

   // ***********************************************************
   // read path and acknowledge
   // ***********************************************************
   wire [31:0] ctrl_rd   = {25'h0, inertia_reg, jump_en_reg, limit_en_reg, mode_reg, run_reg};
   wire [31:0] status_rd = {24'h0, dc_inject_o, output_on_o, done_reg, state_reg, inertia_reg};
   logic [31:0] rd_mux;

   always_comb begin
      case (adr_i)
         OFS_CTRL:             rd_mux = ctrl_rd;
         OFS_TOP_FREQ:         rd_mux = {16'h0, top_reg};
         OFS_START_FREQ:       rd_mux = {16'h0, start_reg};
         OFS_LOWER_LIM:        rd_mux = {16'h0, lower_reg};
         OFS_UPPER_LIM:        rd_mux = {16'h0, upper_reg};
         OFS_JUMP_BASE:        rd_mux = {16'h0, jlo_reg[0]};
         OFS_JUMP_BASE + 8'h4: rd_mux = {16'h0, jhi_reg[0]};
         OFS_JUMP_BASE + 8'h8: rd_mux = {16'h0, jlo_reg[1]};
         OFS_JUMP_BASE + 8'hC: rd_mux = {16'h0, jhi_reg[1]};
         OFS_JUMP_BASE + 8'h10: rd_mux = {16'h0, jlo_reg[2]};
         OFS_JUMP_BASE + 8'h14: rd_mux = {16'h0, jhi_reg[2]};
         OFS_PRE_BLOCK:        rd_mux = {16'h0, pre_block_reg};
         OFS_DC_DUR:           rd_mux = {16'h0, dc_dur_reg};
         OFS_DC_AMT:           rd_mux = {16'h0, dc_amt_reg};
         OFS_BRAKE_FREQ:       rd_mux = {16'h0, brake_freq_reg};
         OFS_CMD_FREQ:         rd_mux = {16'h0, cmd_reg};
         OFS_STATUS:           rd_mux = status_rd;
         OFS_OUT_FREQ:         rd_mux = {16'h0, out_reg};
         OFS_DC_CURRENT:       rd_mux = {16'h0, dc_current_o};
         OFS_RATED_CUR:        rd_mux = {16'h0, rated_reg};
         default:              rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg      <= 1'b0;
         rdata_reg    <= 32'h0000_0000;
         dc_current_o <= 16'h0000;
      end else begin
         ack_reg      <= req;
         rdata_reg    <= req ? rd_mux : 32'h0000_0000;
         dc_current_o <= (state_next == ST_INJECT) ? cur_val : 16'h0000;
      end
   end

   assign ack_o        = ack_reg;
   assign dat_o        = rdata_reg;
   assign freq_out_o   = out_reg;
   assign output_on_o  = (state_reg == ST_RUN) || (state_reg == ST_DECEL);
   assign dc_inject_o  = state_reg == ST_INJECT;
   assign brake_gain_o = inertia_reg;
   assign stop_done_o  = done_reg;
endmodule
`default_nettype wire

// ===== hdl/freq_brake_pkg.sv
// constants, register map and state encoding of the frequency conditioning and stop block
package freq_brake_pkg;
   // ***********************************************************
   // register map (byte offsets, one 32-bit word each)
   // ***********************************************************
   localparam logic [7:0] OFS_CTRL        = 8'h00;
   localparam logic [7:0] OFS_TOP_FREQ    = 8'h04;
   localparam logic [7:0] OFS_START_FREQ  = 8'h08;
   localparam logic [7:0] OFS_LOWER_LIM   = 8'h0C;
   localparam logic [7:0] OFS_UPPER_LIM   = 8'h10;
   localparam logic [7:0] OFS_JUMP_BASE   = 8'h14;
   localparam logic [7:0] OFS_PRE_BLOCK   = 8'h2C;
   localparam logic [7:0] OFS_DC_DUR      = 8'h30;
   localparam logic [7:0] OFS_DC_AMT      = 8'h34;
   localparam logic [7:0] OFS_BRAKE_FREQ  = 8'h38;
   localparam logic [7:0] OFS_CMD_FREQ    = 8'h3C;
   localparam logic [7:0] OFS_STATUS      = 8'h40;
   localparam logic [7:0] OFS_OUT_FREQ    = 8'h44;
   localparam logic [7:0] OFS_DC_CURRENT  = 8'h48;
   localparam logic [7:0] OFS_RATED_CUR   = 8'h4C;

   // ***********************************************************
   // control word fields
   // ***********************************************************
   localparam int CTRL_RUN_BIT     = 0;
   localparam int CTRL_MODE_LSB    = 1;
   localparam int CTRL_LIMIT_BIT   = 3;
   localparam int CTRL_JUMP_BIT    = 4;
   localparam int CTRL_INERTIA_LSB = 5;

   // ***********************************************************
   // settings: frequencies in 0.01 Hz, block time 0.01 s, duration 0.1 s
   // ***********************************************************
   localparam logic [15:0] TOP_MIN         = 16'h0FA0;
   localparam logic [15:0] TOP_MAX         = 16'h9C40;
   localparam logic [15:0] TOP_RST         = 16'h1770;
   localparam logic [15:0] START_MIN       = 16'h000A;
   localparam logic [15:0] START_MAX       = 16'h03E8;
   localparam logic [15:0] START_RST       = 16'h0032;
   localparam logic [15:0] LOWER_RST       = 16'h0032;
   localparam logic [15:0] UPPER_RST       = 16'h1770;
   localparam logic [15:0] JLO_RST [3]     = '{16'h03E8, 16'h07D0, 16'h0BB8};
   localparam logic [15:0] JHI_RST [3]     = '{16'h05DC, 16'h09C4, 16'h0DAC};
   localparam logic [15:0] PRE_BLOCK_MAX   = 16'h1770;
   localparam logic [15:0] PRE_BLOCK_RST   = 16'h0000;
   localparam logic [15:0] DC_DUR_MAX      = 16'h0258;
   localparam logic [15:0] DC_DUR_RST      = 16'h000A;
   localparam logic [15:0] DC_AMT_MAX      = 16'h00C8;
   localparam logic [15:0] DC_AMT_RST      = 16'h0032;
   localparam logic [15:0] BRAKE_FREQ_MAX  = 16'h1770;
   localparam logic [15:0] BRAKE_FREQ_RST  = 16'h01F4;
   localparam logic [15:0] RATED_CUR_RST   = 16'h0064;
   localparam logic [15:0] PERCENT_FULL    = 16'h0064;
   localparam logic [1:0]  MODE_MAX        = 2'h2;
   localparam logic [1:0]  INERTIA_MAX     = 2'h2;
   localparam logic [4:0]  DUR_TICKS_UNIT  = 5'h0A;

   // ***********************************************************
   // timing
   // ***********************************************************
   localparam int CLK_PERIOD_NS   = 25;
   localparam int TICK_TIME_NS    = 10_000_000;
   localparam int TICK_CYCLES_DOC = TICK_TIME_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      STOP_DECEL = 2'h0,
      STOP_DC    = 2'h1,
      STOP_COAST = 2'h2
   } stop_mode_e;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'h0,
      ST_RUN    = 3'h1,
      ST_DECEL  = 3'h3,
      ST_BLOCK  = 3'h2,
      ST_INJECT = 3'h6,
      ST_DONE   = 3'h7
   } stop_state_e;
endpackage

// ===== test/freq_limit_dc_brake_stop_properties.sv
// port checker for the frequency conditioning and stop block
`timescale 1ns/100ps
`default_nettype none
module freq_limit_dc_brake_stop_properties
   import freq_brake_pkg::*;
#(
   parameter int          TICK_CYCLES = 4,
   parameter logic [15:0] RAMP_STEP   = 16'h0064
) (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [7:0]  adr_i,
   input wire logic [3:0]  sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   input wire logic [15:0] freq_out_o,
   input wire logic        output_on_o,
   input wire logic        dc_inject_o,
   input wire logic [15:0] dc_current_o,
   input wire logic [1:0]  brake_gain_o,
   input wire logic        stop_done_o
);
   // a ramp step that lands inside a jump band is carried to the far edge of the band
   localparam logic [15:0] BAND_SPAN = JHI_RST[0] - JLO_RST[0];
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o && !($past(ack_o)))
      else $error("request not acknowledged in the next cycle");
   AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");
   AST_DAT_IDLE: assert property (!ack_o |-> dat_o == 32'h0000_0000)
      else $error("read data not zero outside ack");
   AST_TOP_MAX: assert property (freq_out_o <= TOP_MAX)
      else $error("output frequency above the top setting range");
   AST_RAMP: assert property (output_on_o && $past(output_on_o) |->
      ((freq_out_o >= $past(freq_out_o)) ? freq_out_o - $past(freq_out_o)
                                         : $past(freq_out_o) - freq_out_o) <= RAMP_STEP + BAND_SPAN)
      else $error("output frequency jumped by more than one step");
   AST_INJ_BLOCK: assert property (dc_inject_o |-> !output_on_o)
      else $error("inverter output on during dc injection");
   AST_CUR_ZERO: assert property (!dc_inject_o && !$past(dc_inject_o) |-> dc_current_o == 16'h0000)
      else $error("dc current outside injection");
   AST_CUR_STEADY: assert property (dc_inject_o && $past(dc_inject_o) |-> $stable(dc_current_o))
      else $error("dc current moved during injection");
   AST_GAIN: assert property (brake_gain_o <= INERTIA_MAX)
      else $error("brake gain out of range");
   AST_DONE_OFF: assert property (stop_done_o |-> !output_on_o && !dc_inject_o)
      else $error("stop reported while output active");
   AST_INJ_END: assert property ($fell(dc_inject_o) |-> ##[0:4] stop_done_o)
      else $error("stop not reported after braking");
   COV_INJ: cover property ($rose(dc_inject_o));
   COV_DONE: cover property ($rose(stop_done_o));
   COV_COAST: cover property ($fell(output_on_o) && !dc_inject_o);
endmodule
`default_nettype wire

// ===== test/motor_stage_model.sv
// behavioural power stage: counts dc injection cycles and flags drive during injection
`timescale 1ns/100ps
`default_nettype none
module motor_stage_model (
   input  wire logic clk_i,
   input  wire logic clr_i,
   input  wire logic output_on_i,
   input  wire logic dc_inject_i,
   output var  int   inj_cycles_o,
   output var  logic clash_o
);
   always @(posedge clk_i) begin
      if (clr_i) begin
         inj_cycles_o <= 0;
         clash_o      <= 1'b0;
      end else begin
         if (dc_inject_i === 1'b1) inj_cycles_o <= inj_cycles_o + 1;
         if (dc_inject_i === 1'b1 && output_on_i !== 1'b0) clash_o <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// ===== test/test_freq_limit_dc_brake_stop.sv
// self-checking bench for the frequency conditioning and stop block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_fail++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module test_freq_limit_dc_brake_stop
   import freq_brake_pkg::*;
();
   localparam int INJ_EXP = 10 * 4;
   localparam logic [7:0]  DADR [6] = '{OFS_TOP_FREQ, OFS_START_FREQ, OFS_JUMP_BASE, OFS_DC_DUR,
                                        OFS_DC_AMT, OFS_BRAKE_FREQ};
   localparam logic [15:0] DVAL [6] = '{TOP_RST, START_RST, JLO_RST[0], DC_DUR_RST, DC_AMT_RST,
                                        BRAKE_FREQ_RST};
   logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, output_on_o, dc_inject_o, stop_done_o;
   logic        chk, clr, clash;
   logic [7:0]  adr_i;
   logic [3:0]  sel_i;
   logic [31:0] dat_i, dat_o, rdata, exp_d;
   logic [15:0] freq_out_o, dc_current_o, cmd;
   logic [1:0]  brake_gain_o;
   logic [31:0] exp_q [$];
   int          n_fail, n_compared, cycles, inj;
   integer      seed;

   freq_limit_dc_brake_stop #(.TICK_CYCLES(4)) u_freq_limit_dc_brake_stop (.clk_i(clk_i), .rst_i(rst_i),
      .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .freq_out_o(freq_out_o), .output_on_o(output_on_o),
      .dc_inject_o(dc_inject_o), .dc_current_o(dc_current_o), .brake_gain_o(brake_gain_o),
      .stop_done_o(stop_done_o));
   motor_stage_model u_motor_stage_model (.clk_i(clk_i), .clr_i(clr), .output_on_i(output_on_o),
      .dc_inject_i(dc_inject_o), .inj_cycles_o(inj), .clash_o(clash));

   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   task automatic test_done();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // one classic cycle, released at the edge where ack is seen or after 50 edges without ack
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
      int n;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      chk   <= c;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      rdata = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      chk   <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      bus(1'b1, a, {16'h0000, d}, 1'b0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 32'h0000_0000, 1'b1);
   endtask
   task automatic wait_out(input logic [15:0] e);
      int n;
      n = 0;
      do begin
         bus(1'b0, OFS_OUT_FREQ, 32'h0000_0000, 1'b0);
         n++;
      end while (rdata[15:0] !== e && n < 400);
      rd(OFS_OUT_FREQ, {16'h0000, e});
   endtask
   task automatic wait_hi(ref logic s);
      int n;
      n = 0;
      while (s !== 1'b1 && n < 3000) begin
         @(posedge clk_i);
         #1;
         n++;
      end
   endtask
   task automatic stop_run(input logic [15:0] c);
      clr <= 1'b1;
      wr(OFS_CTRL, c);
      clr <= 1'b0;
      wait_hi(stop_done_o);
   endtask

   always @(posedge clk_i) begin
      if (ack_o === 1'b1 && chk === 1'b1) begin
         exp_d = exp_q.pop_front();
         `CHK(dat_o, exp_d)
      end
   end

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         test_done();
      end
   end

   initial begin
      {rst_i, clr} = 2'b11;
      {cyc_i, stb_i, we_i, chk} = 4'h0;
      adr_i = 8'h00;
      sel_i = 4'hF;
      dat_i = 32'h0000_0000;
      seed = 32'h583d63ed;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      clr   <= 1'b0;
      for (int i = 0; i < 6; i++) rd(DADR[i], {16'h0000, DVAL[i]});
      wr(OFS_TOP_FREQ, 16'h0F9F);
      rd(OFS_TOP_FREQ, {16'h0000, TOP_RST});
      rd(8'hFC, 32'h0000_0000);
      $display("test defaults done");
      wr(OFS_CMD_FREQ, 16'h03E8);
      wr(OFS_CTRL, 16'h0001);
      wait_out(16'h03E8);
      wr(OFS_CMD_FREQ, 16'h0031);
      wait_out(16'h0000);
      $display("test start zeroing done");
      wr(OFS_UPPER_LIM, 16'h0BB8);
      wr(OFS_LOWER_LIM, 16'h07D0);
      wr(OFS_CTRL, 16'h0009);
      cmd = 16'h1388 + 16'($random(seed) & 32'h0000_03FF);
      wr(OFS_CMD_FREQ, cmd);
      wait_out(16'h0BB8);
      wr(OFS_CMD_FREQ, 16'h0020);
      wait_out(16'h07D0);
      $display("test limits done");
      wr(OFS_CTRL, 16'h0011);
      wr(OFS_CMD_FREQ, 16'h1388);
      wait_out(16'h1388);
      wr(OFS_CMD_FREQ, 16'h0898);
      wait_out(16'h09C4);
      wr(OFS_CMD_FREQ, 16'h0320);
      wait_out(16'h0320);
      wr(OFS_CMD_FREQ, 16'h0514);
      wait_out(16'h03E8);
      $display("test jump bands done");
      wr(OFS_DC_DUR, 16'h0001);
      wr(OFS_PRE_BLOCK, 16'h0002);
      wr(OFS_CTRL, 16'h0043);
      clr <= 1'b1;
      wr(OFS_CTRL, 16'h0042);
      clr <= 1'b0;
      wait_hi(dc_inject_o);
      `CHK(dc_current_o, DC_AMT_RST)
      `CHK(brake_gain_o, 2'h2)
      `CHK(output_on_o, 1'b0)
      wait_hi(stop_done_o);
      `CHK(1'(inj >= INJ_EXP && inj <= INJ_EXP + 1), 1'b1)
      `CHK({clash, dc_inject_o, output_on_o}, 3'h0)
      $display("test dc brake stop done");
      wr(OFS_CTRL, 16'h0001);
      wait_out(16'h0514);
      stop_run(16'h0000);
      `CHK({freq_out_o, 16'(inj)}, 32'h0000_0000)
      wr(OFS_DC_AMT, 16'h0000);
      wr(OFS_CTRL, 16'h0003);
      wait_out(16'h0514);
      stop_run(16'h0002);
      `CHK(inj, 0)
      $display("test ramp stops done");
      wr(OFS_CTRL, 16'h0005);
      wait_out(16'h0514);
      wr(OFS_CTRL, 16'h0004);
      @(posedge clk_i);
      #1;
      `CHK({output_on_o, freq_out_o}, 17'h0_0000)
      $display("test coast done");
      test_done();
   end
endmodule
bind freq_limit_dc_brake_stop freq_limit_dc_brake_stop_properties #(.TICK_CYCLES(TICK_CYCLES),
   .RAMP_STEP(RAMP_STEP)) u_freq_limit_dc_brake_stop_properties (.clk_i(clk_i), .rst_i(rst_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
   .dat_o(dat_o), .ack_o(ack_o), .freq_out_o(freq_out_o), .output_on_o(output_on_o),
   .dc_inject_o(dc_inject_o), .dc_current_o(dc_current_o), .brake_gain_o(brake_gain_o),
   .stop_done_o(stop_done_o));
`default_nettype wire
